// *** rtl/mmhac_top.sv ***
// Host access control and power-up configuration of the single-axis motion module
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - Control-source switch sampled once after reset selects the preferred party.
// - Serial host alone attached, no lockout, gets write privilege regardless of switch.
// - Backplane alone communicating gets write privilege regardless of switch.
// - After backplane lockout, backplane alone holds write privilege.
// - Both active, no lockout: switch-selected party writes, other refused.
// - Parameter reads accepted from either party at any time.
// - Error-log read refused from a party without write privilege.
// - Serial-defaults switch sampled after reset picks starting serial parameters.
// - Switch closed: start with fixed default framing and rate.
// - Switch open: start with last saved nonvolatile parameters.
// - Software serial changes allowed only while switch open.
// - Default framing seven data bits, even parity, one stop, 9600 baud.
// - Power-up: inputs one to three predefined, four and five discrete.
// - Five discrete inputs and one output, each user or predefined mode.
// - Drive fault active high; high input flags a fault.
// - Channel 1 unused, first encoder channel 2, second encoder channel 3.
// - Accept A, B and mark from one or two differential encoders.
// - Drive command selectable as velocity or current by software.
// - Analog output setup selects diagnostic or user program control.
module mmhac_top #(
	parameter int ATTACH_CYCLES = mmhac_pkg::MMHAC_ATTACH_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic control_source_switch,
	input wire logic serial_defaults_switch,
	input wire mmhac_pkg::mmhac_req_t backplane_req,
	input wire mmhac_pkg::mmhac_req_t serial_req,
	output logic backplane_accept,
	output logic backplane_refuse,
	output logic serial_accept,
	output logic serial_refuse,
	output logic [1:0] write_owner,
	output logic lockout_active,
	input wire mmhac_pkg::mmhac_serial_t saved_serial,
	input wire logic serial_cfg_wr,
	input wire mmhac_pkg::mmhac_serial_t serial_cfg_data,
	output mmhac_pkg::mmhac_serial_t serial_cfg,
	input wire logic io_mode_wr,
	input wire logic [4:0] io_input_mode_data,
	input wire logic io_output_mode_data,
	output logic [4:0] input_mode,
	output logic output_mode,
	input wire logic [4:0] discrete_in,
	input wire logic discrete_out_data,
	output logic [4:0] discrete_in_q,
	output logic discrete_out,
	input wire logic drive_fault_in,
	output logic drive_fault,
	input wire logic drive_mode_wr,
	input wire logic drive_mode_data,
	output logic drive_mode,
	input wire logic aout_setup_wr,
	input wire logic aout_setup_data,
	output logic aout_mode,
	input wire logic [1:0] enc_present,
	input wire logic [2:0] first_encoder_port,
	input wire logic [2:0] second_encoder_port,
	output logic [2:0] first_encoder_q,
	output logic [2:0] second_encoder_q,
	output logic [1:0] first_encoder_chan,
	output logic [1:0] second_encoder_chan
);
	import mmhac_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Power-up sampling
	logic straps_taken;
	logic prefer_serial;
	logic defaults_closed;
	logic bp_attached;
	logic sr_attached;
	logic [MMHAC_TMR_W-1:0] bp_tmr;
	logic [MMHAC_TMR_W-1:0] sr_tmr;
	logic [1:0] next_owner;
	logic bp_write_ok;
	logic sr_write_ok;

	// Catch both switches once, on the first edge after release
	// strap capture once
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			straps_taken <= 1'b0;
			prefer_serial <= 1'b0;
			defaults_closed <= 1'b0;
		end else if (!straps_taken) begin
			straps_taken <= 1'b1;
			prefer_serial <= control_source_switch;
			defaults_closed <= serial_defaults_switch;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Attach timers, reloaded by each valid request
	// attach window timers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bp_tmr <= '0;
		end else if (backplane_req.valid) begin
			bp_tmr <= MMHAC_TMR_W'(ATTACH_CYCLES);
		end else if (bp_tmr != '0) begin
			bp_tmr <= bp_tmr - 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sr_tmr <= '0;
		end else if (serial_req.valid) begin
			sr_tmr <= MMHAC_TMR_W'(ATTACH_CYCLES);
		end else if (sr_tmr != '0) begin
			sr_tmr <= sr_tmr - 1'b1;
		end
	end

	// A request in this cycle counts as attached already
	assign bp_attached = backplane_req.valid || (bp_tmr != '0);
	assign sr_attached = serial_req.valid || (sr_tmr != '0);

	////////////////////////////////////////////////////////////////////////////////
	// Lockout, set by backplane lockout command, cleared only by reset
	// lockout latch
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lockout_active <= 1'b0;
		end else if (backplane_req.valid && backplane_req.cmd == MMHAC_CMD_LOCKOUT) begin
			lockout_active <= 1'b1;
		end
	end

	// Write privilege arbitration
	always_comb begin
		next_owner = MMHAC_SRC_NONE;
		if (lockout_active) begin
			next_owner = MMHAC_SRC_BACKPLANE;
		end else if (bp_attached && sr_attached) begin
			next_owner = prefer_serial ? MMHAC_SRC_SERIAL : MMHAC_SRC_BACKPLANE;
		end else if (bp_attached) begin
			next_owner = MMHAC_SRC_BACKPLANE;
		end else if (sr_attached) begin
			next_owner = MMHAC_SRC_SERIAL;
		end
	end

	assign bp_write_ok = next_owner == MMHAC_SRC_BACKPLANE;
	assign sr_write_ok = next_owner == MMHAC_SRC_SERIAL;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			write_owner <= MMHAC_SRC_NONE;
		end else begin
			write_owner <= next_owner;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request answers, one cycle after the request
	// per-command gating
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			backplane_accept <= 1'b0;
			backplane_refuse <= 1'b0;
		end else begin
			backplane_accept <= backplane_req.valid &&
				(backplane_req.cmd == MMHAC_CMD_READ || backplane_req.cmd == MMHAC_CMD_LOCKOUT
				|| bp_write_ok);
			backplane_refuse <= backplane_req.valid && !bp_write_ok &&
				(backplane_req.cmd == MMHAC_CMD_WRITE || backplane_req.cmd == MMHAC_CMD_LOG_READ);
		end
	end

	// Serial host may not issue lockout; treat it as a write
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			serial_accept <= 1'b0;
			serial_refuse <= 1'b0;
		end else begin
			serial_accept <= serial_req.valid &&
				(serial_req.cmd == MMHAC_CMD_READ || sr_write_ok);
			serial_refuse <= serial_req.valid && !sr_write_ok &&
				(serial_req.cmd != MMHAC_CMD_READ);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial framing
	// framing selection
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			serial_cfg <= MMHAC_DEF_SERIAL;
		end else if (!straps_taken) begin
			serial_cfg <= serial_defaults_switch ? MMHAC_DEF_SERIAL : saved_serial;
		end else if (serial_cfg_wr && !serial_defaults_switch) begin
			serial_cfg <= serial_cfg_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Discrete I/O modes and data
	// I/O mode registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			input_mode <= MMHAC_INPUT_MODE_RST;
			output_mode <= MMHAC_OUTPUT_MODE_RST;
		end else if (io_mode_wr) begin
			input_mode <= io_input_mode_data;
			output_mode <= io_output_mode_data;
		end
	end

	// Register the inputs per bit and the output level
	// discrete registers
	genvar gi;
	generate
		for (gi = 0; gi < MMHAC_NUM_INPUTS; gi++) begin : g_in
			always_ff @(posedge mclk or negedge reset_n) begin
				if (!reset_n) begin
					discrete_in_q[gi] <= 1'b0;
				end else begin
					discrete_in_q[gi] <= discrete_in[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			discrete_out <= 1'b0;
		end else begin
			discrete_out <= discrete_out_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Drive signals and analog output setup
	// fault is active high
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			drive_fault <= 1'b0;
		end else begin
			drive_fault <= drive_fault_in;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			drive_mode <= MMHAC_DRV_VELOCITY;
			aout_mode <= MMHAC_AOUT_DIAG;
		end else begin
			if (drive_mode_wr) begin
				drive_mode <= drive_mode_data;
			end
			if (aout_setup_wr) begin
				aout_mode <= aout_setup_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Encoder feedback, {mark, B, A}, absent port reads zero
	// encoder channels
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			first_encoder_q <= 3'h0;
			second_encoder_q <= 3'h0;
			first_encoder_chan <= MMHAC_CHAN_UNUSED;
			second_encoder_chan <= MMHAC_CHAN_UNUSED;
		end else begin
			first_encoder_q <= enc_present[0] ? first_encoder_port : 3'h0;
			second_encoder_q <= enc_present[1] ? second_encoder_port : 3'h0;
			first_encoder_chan <= enc_present[0] ? MMHAC_CHAN_FIRST_ENC : MMHAC_CHAN_UNUSED;
			second_encoder_chan <= enc_present[1] ? MMHAC_CHAN_SECOND_ENC : MMHAC_CHAN_UNUSED;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	// lockout gives backplane
	AST_LOCKOUT_OWNER: assert property (@(posedge mclk) disable iff (!reset_n)
		lockout_active |=> write_owner == MMHAC_SRC_BACKPLANE)
		else $error("lockout without backplane ownership");
	AST_LOCKOUT_STICKY: assert property (@(posedge mclk) disable iff (!reset_n)
		lockout_active |=> lockout_active)
		else $error("lockout dropped");
	AST_SERIAL_ALONE: assert property (@(posedge mclk) disable iff (!reset_n)
		(sr_attached && !bp_attached && !lockout_active) |=> write_owner == MMHAC_SRC_SERIAL)
		else $error("lone serial host not owner");
	AST_BP_ALONE: assert property (@(posedge mclk) disable iff (!reset_n)
		(bp_attached && !sr_attached) |=> write_owner == MMHAC_SRC_BACKPLANE)
		else $error("lone backplane not owner");
	AST_BOTH_SWITCH: assert property (@(posedge mclk) disable iff (!reset_n)
		(straps_taken && bp_attached && sr_attached && !lockout_active) |=>
		write_owner == ($past(prefer_serial) ? MMHAC_SRC_SERIAL : MMHAC_SRC_BACKPLANE))
		else $error("switch arbitration wrong");
	AST_READ_ACCEPT: assert property (@(posedge mclk) disable iff (!reset_n)
		(serial_req.valid && serial_req.cmd == MMHAC_CMD_READ) |=> serial_accept && !serial_refuse)
		else $error("serial read not accepted");
	AST_LOG_REFUSE: assert property (@(posedge mclk) disable iff (!reset_n)
		(serial_req.valid && serial_req.cmd == MMHAC_CMD_LOG_READ && !sr_write_ok) |=>
		serial_refuse && !serial_accept)
		else $error("log read without privilege accepted");
	AST_SERIAL_FROZEN: assert property (@(posedge mclk) disable iff (!reset_n)
		(straps_taken && serial_defaults_switch) |=> $stable(serial_cfg))
		else $error("framing changed while switch closed");
	AST_SERIAL_DEFAULT: assert property (@(posedge mclk) disable iff (!reset_n)
		(!straps_taken && serial_defaults_switch) |=> serial_cfg == MMHAC_DEF_SERIAL)
		else $error("default framing not applied");
	AST_FAULT_HIGH: assert property (@(posedge mclk) disable iff (!reset_n)
		drive_fault_in |=> drive_fault)
		else $error("fault not flagged");
	AST_ATTACH_LAPSE: assert property (@(posedge mclk) disable iff (!reset_n)
		(bp_tmr == MMHAC_TMR_W'(1) && !backplane_req.valid) |=> !bp_attached || backplane_req.valid)
		else $error("attach window did not lapse");

	// Main scenario coverage
	COV_LOCKOUT: cover property (@(posedge mclk) disable iff (!reset_n)
		$rose(lockout_active));
	COV_BOTH_SERIAL: cover property (@(posedge mclk) disable iff (!reset_n)
		bp_attached && sr_attached && sr_write_ok);
	COV_LOG_REFUSE: cover property (@(posedge mclk) disable iff (!reset_n)
		serial_refuse);
	COV_CFG_WRITE: cover property (@(posedge mclk) disable iff (!reset_n)
		serial_cfg_wr && !serial_defaults_switch && straps_taken);
endmodule
`default_nettype wire

// *** rtl/mmhac_pkg.sv ***
// Package of constants and types for the motion module host access control block
package mmhac_pkg;
	// Requesting party codes
	localparam logic [1:0] MMHAC_SRC_NONE = 2'h0;
	localparam logic [1:0] MMHAC_SRC_BACKPLANE = 2'h1;
	localparam logic [1:0] MMHAC_SRC_SERIAL = 2'h2;
	// Command kinds
	typedef enum logic [1:0] {
		MMHAC_CMD_READ = 2'b00,
		MMHAC_CMD_WRITE = 2'b01,
		MMHAC_CMD_LOG_READ = 2'b10,
		MMHAC_CMD_LOCKOUT = 2'b11
	} mmhac_cmd_t;
	// One request from a commanding party
	typedef struct packed {
		logic valid;
		mmhac_cmd_t cmd;
	} mmhac_req_t;
	// Serial framing
	typedef struct packed {
		logic [3:0] data_bits;
		logic [1:0] parity;
		logic [1:0] stop_bits;
		logic [19:0] baud;
	} mmhac_serial_t;
	localparam logic [1:0] MMHAC_PAR_NONE = 2'h0;
	localparam logic [1:0] MMHAC_PAR_EVEN = 2'h1;
	localparam logic [1:0] MMHAC_PAR_ODD = 2'h2;
	localparam logic [3:0] MMHAC_DEF_DATA_BITS = 4'h7;
	localparam logic [1:0] MMHAC_DEF_STOP_BITS = 2'h1;
	localparam logic [19:0] MMHAC_DEF_BAUD = 20'h02580;
	localparam mmhac_serial_t MMHAC_DEF_SERIAL = '{MMHAC_DEF_DATA_BITS, MMHAC_PAR_EVEN,
		MMHAC_DEF_STOP_BITS, MMHAC_DEF_BAUD};
	// Discrete I/O power-up modes, 1 predefined, 0 plain discrete
	localparam int MMHAC_NUM_INPUTS = 5;
	localparam logic [4:0] MMHAC_INPUT_MODE_RST = 5'h07;
	localparam logic MMHAC_OUTPUT_MODE_RST = 1'b0;
	// Feedback channel numbers
	localparam logic [1:0] MMHAC_CHAN_UNUSED = 2'h1;
	localparam logic [1:0] MMHAC_CHAN_FIRST_ENC = 2'h2;
	localparam logic [1:0] MMHAC_CHAN_SECOND_ENC = 2'h3;
	// Drive command modes
	localparam logic MMHAC_DRV_VELOCITY = 1'b0;
	localparam logic MMHAC_DRV_CURRENT = 1'b1;
	// Analog output modes
	localparam logic MMHAC_AOUT_DIAG = 1'b0;
	localparam logic MMHAC_AOUT_USER = 1'b1;
	// Attach timeout
	localparam int MMHAC_CLK_HZ = 20000000;
	localparam int MMHAC_ATTACH_TIMEOUT_MS = 500;
	localparam int MMHAC_ATTACH_CYCLES = MMHAC_CLK_HZ / 1000 * MMHAC_ATTACH_TIMEOUT_MS;
	localparam int MMHAC_TMR_W = 24;
endpackage

// *** dv/mmhac_host_model.sv ***
// Commanding party model that issues one-cycle requests to the access block
`timescale 1ns/1ns
`default_nettype none
module mmhac_host_model (
	input wire logic clk,
	output var mmhac_pkg::mmhac_req_t req
);
	import mmhac_pkg::*;
	initial begin
		req = '0;
	end
	// valid request pulse
	// Valid stands for one edge only, then the request is dropped
	task automatic send(input mmhac_cmd_t c);
		req <= '{1'b1, c};
		@(posedge clk);
		req <= '0;
	endtask
endmodule
`default_nettype wire

// *** dv/mmhac_top_bench.sv ***
// Self-checking bench for the host access control block
`timescale 1ns/1ns
`default_nettype none
module mmhac_top_bench;
	import mmhac_pkg::*;
	localparam int ATT = 20;
	localparam logic [1:0] ACC = 2'b10;
	localparam logic [1:0] REF = 2'b01;
	localparam mmhac_serial_t DEF = '{4'h7, MMHAC_PAR_EVEN, 2'h1, 20'h02580};
	localparam mmhac_serial_t SAVED = '{4'h8, MMHAC_PAR_ODD, 2'h2, 20'h04b00};
	localparam mmhac_serial_t SOFT = '{4'h8, MMHAC_PAR_NONE, 2'h1, 20'h1c200};
	logic mclk = 1'b0;
	logic reset_n, cs_sw, sd_sw, cfg_wr, io_wr, out_md, dout, dflt;
	logic dm_wr, dm_data, ao_wr, ao_data;
	logic bp_acc, bp_ref, sr_acc, sr_ref, lock, output_mode, dout_q, drive_fault;
	logic drive_mode, aout_mode;
	logic [1:0] owner, enc_present, e1_ch, e2_ch;
	logic [2:0] e1, e2, e1_q, e2_q;
	logic [4:0] in_md, input_mode, din, din_q;
	mmhac_req_t bp_req, sr_req;
	mmhac_serial_t saved, cfg_data, serial_cfg;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Clock, parties and design
	always #25 mclk = ~mclk;
	mmhac_host_model bp_host (.clk(mclk), .req(bp_req));
	mmhac_host_model sr_host (.clk(mclk), .req(sr_req));
	mmhac_top #(.ATTACH_CYCLES(ATT)) DUT (.mclk(mclk), .reset_n(reset_n),
		.control_source_switch(cs_sw), .serial_defaults_switch(sd_sw),
		.backplane_req(bp_req), .serial_req(sr_req), .backplane_accept(bp_acc),
		.backplane_refuse(bp_ref), .serial_accept(sr_acc), .serial_refuse(sr_ref),
		.write_owner(owner), .lockout_active(lock), .saved_serial(saved),
		.serial_cfg_wr(cfg_wr), .serial_cfg_data(cfg_data), .serial_cfg(serial_cfg),
		.io_mode_wr(io_wr), .io_input_mode_data(in_md), .io_output_mode_data(out_md),
		.input_mode(input_mode), .output_mode(output_mode), .discrete_in(din),
		.discrete_out_data(dout), .discrete_in_q(din_q), .discrete_out(dout_q),
		.drive_fault_in(dflt), .drive_fault(drive_fault), .drive_mode_wr(dm_wr),
		.drive_mode_data(dm_data), .drive_mode(drive_mode), .aout_setup_wr(ao_wr),
		.aout_setup_data(ao_data), .aout_mode(aout_mode), .enc_present(enc_present),
		.first_encoder_port(e1), .second_encoder_port(e2), .first_encoder_q(e1_q),
		.second_encoder_q(e2_q), .first_encoder_chan(e1_ch), .second_encoder_chan(e2_ch));

	////////////////////////////////////////////////////////////////////////////////
	// Verdict, comparison and access tasks
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask
	// One request, then the answer pulse pair in the cycle it stands
	task automatic ask(input bit ser, input mmhac_cmd_t c, input logic [1:0] exp);
		@(posedge mclk);
		if (ser) begin
			sr_host.send(c);
			#1;
			check("serial answer", 32'(exp), 32'({sr_acc, sr_ref}));
		end else begin
			bp_host.send(c);
			#1;
			check("backplane answer", 32'(exp), 32'({bp_acc, bp_ref}));
		end
	endtask
	// Framing write pulse, result one cycle later
	task automatic cfg_write(input mmhac_serial_t v);
		@(posedge mclk);
		cfg_wr <= 1'b1;
		cfg_data <= v;
		@(posedge mclk);
		cfg_wr <= 1'b0;
		#1;
	endtask
	task automatic do_reset(input logic cs, input logic sd);
		@(posedge mclk);
		reset_n <= 1'b0;
		cs_sw <= cs;
		sd_sw <= sd;
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	// Cycle ceiling against a hung run
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			err_count++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		{reset_n, cs_sw, sd_sw, cfg_wr, io_wr, out_md, dout, dflt} = '0;
		{dm_wr, dm_data, ao_wr, ao_data, in_md, din, e1, e2} = '0;
		enc_present = 2'b11;
		saved = SAVED;
		cfg_data = SOFT;
		do_reset(1'b0, 1'b1);
		check("serial_cfg", 32'(DEF), 32'(serial_cfg)); // defaults
		check("input_mode", 32'h07, 32'(input_mode)); // power-up modes
		check("output_mode", 32'h0, 32'(output_mode)); // output mode
		check("first chan", 32'h2, 32'(e1_ch)); // first port
		check("second chan", 32'h3, 32'(e2_ch)); // second port
		check("drive_fault", 32'h0, 32'(drive_fault)); // low input
		cfg_write(SOFT);
		check("serial_cfg closed", 32'(DEF), 32'(serial_cfg)); // ignored
		ask(1'b1, MMHAC_CMD_WRITE, ACC); // serial alone
		check("owner", 32'(MMHAC_SRC_SERIAL), 32'(owner)); // owner
		ask(1'b0, MMHAC_CMD_WRITE, ACC); // preferred party
		ask(1'b1, MMHAC_CMD_WRITE, REF); // other refused
		ask(1'b1, MMHAC_CMD_LOG_READ, REF); // log refused
		ask(1'b1, MMHAC_CMD_READ, ACC); // read allowed
		ask(1'b0, MMHAC_CMD_LOG_READ, ACC); // owner log read
		// Let the backplane attach window run out
		repeat (ATT + 2) @(posedge mclk);
		ask(1'b1, MMHAC_CMD_WRITE, ACC); // backplane window lapsed
		check("owner lapsed", 32'(MMHAC_SRC_SERIAL), 32'(owner)); // owner
		sd_sw <= 1'b0;
		cfg_write(SOFT);
		check("serial_cfg open", 32'(SOFT), 32'(serial_cfg)); // change taken
		do_reset(1'b1, 1'b0);
		check("serial_cfg saved", 32'(SAVED), 32'(serial_cfg)); // saved
		cs_sw <= 1'b0;
		ask(1'b0, MMHAC_CMD_WRITE, ACC); // backplane alone
		ask(1'b1, MMHAC_CMD_WRITE, ACC); // serial preferred
		ask(1'b0, MMHAC_CMD_WRITE, REF); // sampled switch
		check("owner", 32'(MMHAC_SRC_SERIAL), 32'(owner)); // owner
		ask(1'b0, MMHAC_CMD_READ, ACC); // read allowed
		ask(1'b0, MMHAC_CMD_LOCKOUT, ACC); // lockout
		check("lockout", 32'h1, 32'(lock)); // lockout set
		ask(1'b1, MMHAC_CMD_WRITE, REF); // serial locked out
		ask(1'b1, MMHAC_CMD_LOCKOUT, REF); // serial lockout refused
		ask(1'b1, MMHAC_CMD_READ, ACC); // read under lockout
		ask(1'b0, MMHAC_CMD_WRITE, ACC); // backplane writes
		check("owner", 32'(MMHAC_SRC_BACKPLANE), 32'(owner)); // owner
		@(posedge mclk);
		{io_wr, dm_wr, ao_wr, out_md, dm_data, ao_data, dout, dflt} <= 8'hff;
		{in_md, din, e1, e2} <= {5'h18, 5'h15, 3'h5, 3'h6};
		@(posedge mclk);
		{io_wr, dm_wr, ao_wr} <= 3'h0;
		repeat (2) @(posedge mclk);
		#1;
		check("input_mode", 32'h18, 32'(input_mode)); // input modes
		check("output_mode", 32'h1, 32'(output_mode)); // output mode
		check("discrete_in_q", 32'h15, 32'(din_q)); // inputs
		check("discrete_out", 32'h1, 32'(dout_q)); // output
		check("drive_fault", 32'h1, 32'(drive_fault)); // high flags
		check("drive_mode", 32'(MMHAC_DRV_CURRENT), 32'(drive_mode)); // current
		check("aout_mode", 32'(MMHAC_AOUT_USER), 32'(aout_mode)); // user
		check("first_q", 32'h5, 32'(e1_q)); // first encoder
		check("second_q", 32'h6, 32'(e2_q)); // second encoder
		enc_present <= 2'b01;
		repeat (2) @(posedge mclk);
		#1;
		check("second chan", 32'h1, 32'(e2_ch)); // absent port
		check("second_q", 32'h0, 32'(e2_q)); // absent port
		final_report();
	end
endmodule
`default_nettype wire
